// [hw/sfse_exec.sv]
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "sfse_regs.svh"
module sfse_exec
#(
	parameter logic [7:0] RESET_PULSE_CYCLES = `SFSE_RESET_PULSE_CYCLES
)
(
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic INSTR_VALID,
	input wire sfse_pkg::sfse_instr_t INSTR,
	output logic INSTR_READY,
	output sfse_pkg::sfse_mem_req_t MEM_REQ,
	input wire logic [15:0] MEM_RDATA,
	output sfse_pkg::sfse_result_t RESULT,
	output logic [15:0] PC,
	output logic INT_INHIBIT,
	output logic RESET_PULSE,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [`SFSE_AXI_ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	output logic [1:0] S_AXI_BRESP,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	input wire logic [`SFSE_AXI_ADDR_W-1:0] S_AXI_ARADDR,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP
);
	import sfse_pkg::*;

	sfse_state_t s;
	sfse_state_t next_s;
	sfse_width_t shift_width;
	logic [4:0] shift_count;
	logic [31:0] shift_result;
	logic shift_carry;
	logic shift_zero;
	logic shift_ovf;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
		begin
			if (strb[b])
			begin
				r[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic is_shift(input logic [7:0] op);
		return (op == `SFSE_OP_WORD_LEFT) || (op == `SFSE_OP_BYTE_LEFT)
			|| (op == `SFSE_OP_DWORD_LEFT);
	endfunction

	// ----------------------------------------
	// Left shift unit
	// ----------------------------------------
	always_comb
	begin
		case (INSTR.opcode)
			`SFSE_OP_BYTE_LEFT: shift_width = SFSE_W_BYTE;
			`SFSE_OP_DWORD_LEFT: shift_width = SFSE_W_DWORD;
			default: shift_width = SFSE_W_WORD;
		endcase
		// Small count byte is an immediate, larger is a register's content
		if (INSTR.aux < `SFSE_IMM_COUNT_LIMIT)
		begin
			shift_count = INSTR.aux[4:0];
		end
		else
		begin
			shift_count = INSTR.count_reg[4:0];
		end
	end

	sfse_left_shifter u_shifter
	(
		.value(INSTR.operand),
		.count(shift_count),
		.width(shift_width),
		.carry_in(s.processor_flags_word[`SFSE_F_CARRY]),
		.result(shift_result),
		.carry_out(shift_carry),
		.zero(shift_zero),
		.overflow(shift_ovf)
	);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		logic [31:0] merged;
		logic [10:0] disp;
		merged = 32'h00000000;
		disp = {INSTR.opcode[2:0], INSTR.aux};
		next_s = s;
		next_s.mem.re = 1'b0;
		next_s.mem.we = 1'b0;
		next_s.result.valid = 1'b0;

		// Register bus, write side
		if (S_AXI_AWVALID && s.awready)
		begin
			next_s.aw_got = 1'b1;
			next_s.aw_addr = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && s.wready)
		begin
			next_s.w_got = 1'b1;
			next_s.w_data = S_AXI_WDATA;
			next_s.w_strb = S_AXI_WSTRB;
		end
		if (S_AXI_BREADY && s.bvalid)
		begin
			next_s.bvalid = 1'b0;
		end
		if (next_s.aw_got && next_s.w_got && !next_s.bvalid)
		begin
			next_s.aw_got = 1'b0;
			next_s.w_got = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = `SFSE_RESP_OKAY;
			case (next_s.aw_addr)
				`SFSE_REG_STACK:
				begin
					merged = merge({16'h0000, s.stack_pointer}, next_s.w_data, next_s.w_strb);
					next_s.stack_pointer = merged[15:0];
				end
				`SFSE_REG_FLAGS:
				begin
					merged = merge({16'h0000, s.processor_flags_word}, next_s.w_data,
						next_s.w_strb);
					next_s.processor_flags_word = merged[15:0];
				end
				`SFSE_REG_MASKS:
				begin
					merged = merge({16'h0000, s.interrupt_mask_high, s.window_select},
						next_s.w_data, next_s.w_strb);
					next_s.interrupt_mask_high = merged[15:8];
					next_s.window_select = merged[7:0];
				end
				`SFSE_REG_PC, `SFSE_REG_STATUS:
				begin
					next_s.bresp = `SFSE_RESP_OKAY;
				end
				default: next_s.bresp = `SFSE_RESP_SLVERR;
			endcase
		end

		// Register bus, read side
		if (S_AXI_RREADY && s.rvalid)
		begin
			next_s.rvalid = 1'b0;
		end
		if (S_AXI_ARVALID && s.arready)
		begin
			next_s.rvalid = 1'b1;
			next_s.rresp = `SFSE_RESP_OKAY;
			next_s.rdata = 32'h00000000;
			case (S_AXI_ARADDR)
				`SFSE_REG_STACK: next_s.rdata[15:0] = s.stack_pointer;
				`SFSE_REG_FLAGS: next_s.rdata[15:0] = s.processor_flags_word;
				`SFSE_REG_MASKS: next_s.rdata[15:0] = {s.interrupt_mask_high, s.window_select};
				`SFSE_REG_PC: next_s.rdata[15:0] = s.pc;
				`SFSE_REG_STATUS:
				begin
					next_s.rdata[`SFSE_STAT_BUSY] = !s.instr_ready;
					next_s.rdata[`SFSE_STAT_INHIBIT] = s.inhibit;
					next_s.rdata[`SFSE_STAT_RESET_PULSE] = s.rst_pulse;
				end
				default: next_s.rresp = `SFSE_RESP_SLVERR;
			endcase
		end

		// Reset pin pulse stretcher
		if (s.rst_count != 8'h00)
		begin
			next_s.rst_count = s.rst_count - 8'h01;
		end

		// Execution; it runs after the bus so an instruction wins a same-cycle clash
		case (s.phase)
			SFSE_PH_IDLE:
			begin
				if (INSTR_VALID && s.instr_ready)
				begin
					next_s.inhibit = 1'b0;
					next_s.pc = INSTR.next_pc;
					if (INSTR.opcode[7:2] == `SFSE_OP_POP_HI || INSTR.opcode == `SFSE_OP_TAKE_ALL
						|| INSTR.opcode == `SFSE_OP_TAKE_FLAGS || INSTR.opcode == `SFSE_OP_SUB_EXIT)
					begin
						next_s.mem.re = 1'b1;
						next_s.mem.addr = s.stack_pointer;
						next_s.stack_pointer = s.stack_pointer + `SFSE_STACK_STEP;
						next_s.phase = SFSE_PH_POP;
						next_s.instr_ready = 1'b0;
						case (INSTR.opcode)
							`SFSE_OP_TAKE_ALL: next_s.pop_target = SFSE_TO_MASKS;
							`SFSE_OP_TAKE_FLAGS: next_s.pop_target = SFSE_TO_FLAGS;
							`SFSE_OP_SUB_EXIT: next_s.pop_target = SFSE_TO_PC;
							default: next_s.pop_target = SFSE_TO_DEST;
						endcase
					end
					else if (INSTR.opcode[7:2] == `SFSE_OP_PUSH_HI)
					begin
						next_s.stack_pointer = s.stack_pointer - `SFSE_STACK_STEP;
						next_s.mem.we = 1'b1;
						next_s.mem.addr = s.stack_pointer - `SFSE_STACK_STEP;
						next_s.mem.wdata = INSTR.operand[15:0];
					end
					else if (INSTR.opcode == `SFSE_OP_PUT_ALL || INSTR.opcode == `SFSE_OP_PUT_FLAGS)
					begin
						next_s.stack_pointer = s.stack_pointer - `SFSE_STACK_STEP;
						next_s.mem.we = 1'b1;
						next_s.mem.addr = s.stack_pointer - `SFSE_STACK_STEP;
						next_s.mem.wdata = s.processor_flags_word;
						next_s.processor_flags_word = 16'h0000;
						if (INSTR.opcode == `SFSE_OP_PUT_ALL)
						begin
							next_s.phase = SFSE_PH_PUSH2;
							next_s.instr_ready = 1'b0;
						end
						else
						begin
							next_s.inhibit = 1'b1;
						end
					end
					else if (INSTR.opcode[7:3] == `SFSE_OP_NEAR_CALL_HI)
					begin
						next_s.stack_pointer = s.stack_pointer - `SFSE_STACK_STEP;
						next_s.mem.we = 1'b1;
						next_s.mem.addr = s.stack_pointer - `SFSE_STACK_STEP;
						next_s.mem.wdata = INSTR.next_pc;
						next_s.pc = INSTR.next_pc + {{5{disp[10]}}, disp};
					end
					else if (INSTR.opcode == `SFSE_OP_CARRY_ONE)
					begin
						next_s.processor_flags_word[`SFSE_F_CARRY] = 1'b1;
					end
					else if (INSTR.opcode == `SFSE_OP_SOFT_RESET)
					begin
						next_s.processor_flags_word = 16'h0000;
						next_s.pc = `SFSE_PC_RESTART;
						next_s.interrupt_mask_high = 8'h00;
						next_s.window_select = 8'h00;
						next_s.rst_count = RESET_PULSE_CYCLES;
					end
					else if (is_shift(INSTR.opcode))
					begin
						next_s.result.valid = 1'b1;
						next_s.result.width = shift_width;
						next_s.result.data = shift_result;
						next_s.processor_flags_word[`SFSE_F_ZERO] = shift_zero;
						next_s.processor_flags_word[`SFSE_F_OVF] = shift_ovf;
						next_s.processor_flags_word[`SFSE_F_CARRY] = shift_carry;
						if (shift_ovf)
						begin
							next_s.processor_flags_word[`SFSE_F_OVF_TRAP] = 1'b1;
						end
					end
				end
			end
			SFSE_PH_POP:
			begin
				next_s.phase = SFSE_PH_IDLE;
				next_s.instr_ready = 1'b1;
				case (s.pop_target)
					SFSE_TO_MASKS:
					begin
						// First word of pop-all, then fetch the flags word
						next_s.interrupt_mask_high = MEM_RDATA[15:8];
						next_s.window_select = MEM_RDATA[7:0];
						next_s.mem.re = 1'b1;
						next_s.mem.addr = s.stack_pointer;
						next_s.stack_pointer = s.stack_pointer + `SFSE_STACK_STEP;
						next_s.pop_target = SFSE_TO_FLAGS;
						next_s.phase = SFSE_PH_POP;
						next_s.instr_ready = 1'b0;
					end
					SFSE_TO_FLAGS:
					begin
						next_s.processor_flags_word = MEM_RDATA;
						next_s.inhibit = 1'b1;
					end
					SFSE_TO_PC: next_s.pc = MEM_RDATA;
					default:
					begin
						next_s.result.valid = 1'b1;
						next_s.result.width = SFSE_W_WORD;
						next_s.result.data = {16'h0000, MEM_RDATA};
					end
				endcase
			end
			SFSE_PH_PUSH2:
			begin
				next_s.stack_pointer = s.stack_pointer - `SFSE_STACK_STEP;
				next_s.mem.we = 1'b1;
				next_s.mem.addr = s.stack_pointer - `SFSE_STACK_STEP;
				next_s.mem.wdata = {s.interrupt_mask_high, s.window_select};
				next_s.interrupt_mask_high = 8'h00;
				next_s.inhibit = 1'b1;
				next_s.phase = SFSE_PH_IDLE;
				next_s.instr_ready = 1'b1;
			end
			default:
			begin
				next_s.phase = SFSE_PH_IDLE;
				next_s.instr_ready = 1'b1;
			end
		endcase

		next_s.rst_pulse = (next_s.rst_count != 8'h00);
		next_s.awready = !next_s.aw_got && !next_s.bvalid;
		next_s.wready = !next_s.w_got && !next_s.bvalid;
		next_s.arready = !next_s.rvalid;
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			s <= '0;
			s.phase <= SFSE_PH_IDLE;
			s.stack_pointer <= `SFSE_STACK_RESET;
			s.pc <= `SFSE_PC_RESTART;
			s.instr_ready <= 1'b1;
			s.awready <= 1'b1;
			s.wready <= 1'b1;
			s.arready <= 1'b1;
		end
		else
		begin
			s <= next_s;
		end
	end

	assign INSTR_READY = s.instr_ready;
	assign MEM_REQ = s.mem;
	assign RESULT = s.result;
	assign PC = s.pc;
	assign INT_INHIBIT = s.inhibit;
	assign RESET_PULSE = s.rst_pulse;
	assign S_AXI_AWREADY = s.awready;
	assign S_AXI_WREADY = s.wready;
	assign S_AXI_BVALID = s.bvalid;
	assign S_AXI_BRESP = s.bresp;
	assign S_AXI_ARREADY = s.arready;
	assign S_AXI_RVALID = s.rvalid;
	assign S_AXI_RDATA = s.rdata;
	assign S_AXI_RRESP = s.rresp;

endmodule // sfse_exec

// [hw/sfse_regs.svh]
`ifndef SFSE_REGS_SVH
`define SFSE_REGS_SVH

// ----------------------------------------
// Register offsets on the AXI4-Lite slave
// ----------------------------------------
`define SFSE_AXI_ADDR_W 8
`define SFSE_REG_STACK 8'h00
`define SFSE_REG_FLAGS 8'h04
`define SFSE_REG_MASKS 8'h08
`define SFSE_REG_PC 8'h0C
`define SFSE_REG_STATUS 8'h10

// ----------------------------------------
// Field positions in the flags word
// ----------------------------------------
`define SFSE_F_ZERO 15
`define SFSE_F_NEG 14
`define SFSE_F_OVF 13
`define SFSE_F_OVF_TRAP 12
`define SFSE_F_CARRY 11
`define SFSE_F_INT_EN 9
`define SFSE_F_SHIFTED_ONE 8

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define SFSE_STAT_BUSY 0
`define SFSE_STAT_INHIBIT 1
`define SFSE_STAT_RESET_PULSE 2

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define SFSE_OP_POP_HI 6'h33
`define SFSE_OP_PUSH_HI 6'h32
`define SFSE_OP_NEAR_CALL_HI 5'h05
`define SFSE_OP_TAKE_ALL 8'hF5
`define SFSE_OP_TAKE_FLAGS 8'hF3
`define SFSE_OP_PUT_ALL 8'hF4
`define SFSE_OP_PUT_FLAGS 8'hF2
`define SFSE_OP_SUB_EXIT 8'hF0
`define SFSE_OP_SOFT_RESET 8'hFF
`define SFSE_OP_CARRY_ONE 8'hF9
`define SFSE_OP_WORD_LEFT 8'h09
`define SFSE_OP_BYTE_LEFT 8'h19
`define SFSE_OP_DWORD_LEFT 8'h0D

// ----------------------------------------
// Reset values, steps, counts and bus response codes
// ----------------------------------------
`define SFSE_PC_RESTART 16'h2080
`define SFSE_STACK_RESET 16'h0000
`define SFSE_STACK_STEP 16'h0002
`define SFSE_IMM_COUNT_LIMIT 8'h10
`define SFSE_RESET_PULSE_CYCLES 8'h10
`define SFSE_RESP_OKAY 2'h0
`define SFSE_RESP_SLVERR 2'h2

`endif

// [hw/sfse_pkg.sv]
package sfse_pkg;

	typedef enum logic [1:0] {SFSE_W_BYTE, SFSE_W_WORD, SFSE_W_DWORD} sfse_width_t;
	typedef enum logic [1:0] {SFSE_PH_IDLE, SFSE_PH_POP, SFSE_PH_PUSH2} sfse_phase_t;
	typedef enum logic [1:0] {SFSE_TO_DEST, SFSE_TO_FLAGS, SFSE_TO_MASKS, SFSE_TO_PC} sfse_target_t;

	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] aux;
		logic [7:0] count_reg;
		logic [31:0] operand;
		logic [15:0] next_pc;
	} sfse_instr_t;

	typedef struct packed {
		logic re;
		logic we;
		logic [15:0] addr;
		logic [15:0] wdata;
	} sfse_mem_req_t;

	typedef struct packed {
		logic valid;
		sfse_width_t width;
		logic [31:0] data;
	} sfse_result_t;

	typedef struct packed {
		sfse_phase_t phase;
		sfse_target_t pop_target;
		logic [15:0] stack_pointer;
		logic [15:0] processor_flags_word;
		logic [7:0] interrupt_mask_high;
		logic [7:0] window_select;
		logic [15:0] pc;
		logic inhibit;
		logic [7:0] rst_count;
		logic rst_pulse;
		logic instr_ready;
		sfse_mem_req_t mem;
		sfse_result_t result;
		logic aw_got;
		logic [7:0] aw_addr;
		logic w_got;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} sfse_state_t;

endpackage

// [hw/sfse_left_shifter.sv]
`timescale 1ns/1ps
module sfse_left_shifter
(
	input wire logic [31:0] value,
	input wire logic [4:0] count,
	input wire sfse_pkg::sfse_width_t width,
	input wire logic carry_in,
	output logic [31:0] result,
	output logic carry_out,
	output logic zero,
	output logic overflow
);
	import sfse_pkg::*;

	function automatic logic top_bit(input logic [31:0] v, input sfse_width_t w);
		case (w)
			SFSE_W_BYTE: return v[7];
			SFSE_W_WORD: return v[15];
			default: return v[31];
		endcase
	endfunction

	function automatic logic [31:0] trim(input logic [31:0] v, input sfse_width_t w);
		case (w)
			SFSE_W_BYTE: return {24'h000000, v[7:0]};
			SFSE_W_WORD: return {16'h0000, v[15:0]};
			default: return v;
		endcase
	endfunction

	// ----------------------------------------
	// One doubling per count step
	// ----------------------------------------
	always_comb
	begin
		logic [31:0] acc;
		logic c;
		logic v;
		acc = trim(value, width);
		c = carry_in;
		v = 1'b0;
		for (int i = 0; i < 31; i++)
		begin
			if (5'(i) < count)
			begin
				c = top_bit(acc, width);
				acc = trim({acc[30:0], 1'b0}, width);
				// Sign changed during the move
				if (top_bit(acc, width) != c)
				begin
					v = 1'b1;
				end
			end
		end
		result = acc;
		carry_out = c;
		zero = (acc == 32'h00000000);
		overflow = v;
	end

endmodule // sfse_left_shifter

// [testbench/sfse_mem_model.sv]
`timescale 1ns/1ps
module sfse_mem_model
import sfse_pkg::*;
(
	input wire logic clk,
	input wire sfse_pkg::sfse_mem_req_t req,
	output logic [15:0] rdata
);
	logic [15:0] mem [0:32767];
	always @(posedge clk)
	begin
		if (req.we)
			mem[req.addr[15:1]] <= req.wdata;
	end
	// The core takes read data in the cycle re stands; outside a read the inverse shows
	always_comb
	begin
		if (req.re)
			rdata = mem[req.addr[15:1]];
		else
			rdata = ~mem[req.addr[15:1]];
	end
endmodule // sfse_mem_model

// [testbench/sfse_exec_properties.sv]
`timescale 1ns/1ps
module sfse_exec_properties
import sfse_pkg::*;
#(
	parameter logic [7:0] RESET_PULSE_CYCLES = 8'h10
)
(
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic INSTR_VALID,
	input wire sfse_pkg::sfse_instr_t INSTR,
	input wire logic INSTR_READY,
	input wire sfse_pkg::sfse_mem_req_t MEM_REQ,
	input wire sfse_pkg::sfse_result_t RESULT,
	input wire logic [15:0] PC,
	input wire logic INT_INHIBIT,
	input wire logic RESET_PULSE
);
	logic tk;
	logic [7:0] op;
	logic lock;
	logic [7:0] pulse_len;
	assign tk = INSTR_VALID && INSTR_READY;
	assign op = INSTR.opcode;
	assign lock = op inside {8'hF2, 8'hF3, 8'hF4, 8'hF5};
	always_ff @(posedge CLK or negedge RST_N)
		if (!RST_N)
			pulse_len <= 8'h00;
		else if (RESET_PULSE)
			pulse_len <= pulse_len + 8'h01;
		else
			pulse_len <= 8'h00;
	default clocking @(posedge CLK);
	endclocking
	default disable iff (!RST_N);
	a_push_write:
		assert property (tk && op[7:2] == 6'h32 |=> MEM_REQ.we
			&& MEM_REQ.wdata == $past(INSTR.operand[15:0])) else $error("push word wrong");
	a_pop_read:
		assert property (tk && op[7:2] == 6'h33 |=> MEM_REQ.re ##[1:2] RESULT.valid)
		else $error("pop without result");
	a_flag_push:
		assert property (tk && op == 8'hF2 |=> MEM_REQ.we ##[0:1] INT_INHIBIT)
		else $error("flag push not locked");
	a_lock_set:
		assert property (tk && lock |=> ##[0:2] (INT_INHIBIT && INSTR_READY))
		else $error("lockout missing");
	a_lock_drop:
		assert property (tk && !lock |=> !INT_INHIBIT) else $error("lockout held too long");
	a_call_pc:
		assert property (tk && op[7:3] == 5'h05 |=> MEM_REQ.we
			&& MEM_REQ.wdata == $past(INSTR.next_pc) && PC == $past(INSTR.next_pc)
			+ {{5{$past(op[2])}}, $past(op[2:0]), $past(INSTR.aux)}) else $error("call wrong");
	a_rst_pc:
		assert property (tk && op == 8'hFF |=> PC == 16'h2080 && RESET_PULSE)
		else $error("restart wrong");
	a_pulse_len:
		assert property ($fell(RESET_PULSE) |-> pulse_len == RESET_PULSE_CYCLES)
		else $error("reset pulse length wrong");
	a_shift_done:
		assert property (tk && op inside {8'h09, 8'h19, 8'h0D} |=> RESULT.valid)
		else $error("shift without result");
	a_carry_quiet:
		assert property (tk && op == 8'hF9 |=> !MEM_REQ.we && !MEM_REQ.re && !RESULT.valid)
		else $error("carry force touched memory");
endmodule // sfse_exec_properties

bind sfse_exec sfse_exec_properties #(.RESET_PULSE_CYCLES(RESET_PULSE_CYCLES)) u_props (
	.CLK(CLK), .RST_N(RST_N), .INSTR_VALID(INSTR_VALID), .INSTR(INSTR),
	.INSTR_READY(INSTR_READY), .MEM_REQ(MEM_REQ), .RESULT(RESULT), .PC(PC),
	.INT_INHIBIT(INT_INHIBIT), .RESET_PULSE(RESET_PULSE));

// [testbench/test_stack_flag_shift_exec.sv]
`timescale 1ns/1ps
`include "sfse_regs.svh"
module test_stack_flag_shift_exec;
	import sfse_pkg::*;
	logic CLK = 1'b0;
	logic RST_N = 1'b0;
	logic INSTR_VALID = 1'b0;
	sfse_instr_t INSTR = '0;
	logic INSTR_READY, INT_INHIBIT, RESET_PULSE, awr, wr, bv, arr, rv;
	sfse_mem_req_t MEM_REQ;
	sfse_result_t RESULT;
	logic [15:0] MEM_RDATA, PC, stk, fl, mk, npc;
	logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
	logic [7:0] awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0, rdata;
	logic [1:0] bresp, rresp;
	int fail_count = 0;
	int samples_checked = 0;
	logic [31:0] rq[$], wq[$], aq[$];
	always #2 CLK = ~CLK;
	sfse_exec #(.RESET_PULSE_CYCLES(8'h04)) dut (.CLK(CLK), .RST_N(RST_N),
		.INSTR_VALID(INSTR_VALID), .INSTR(INSTR), .INSTR_READY(INSTR_READY),
		.MEM_REQ(MEM_REQ), .MEM_RDATA(MEM_RDATA), .RESULT(RESULT), .PC(PC),
		.INT_INHIBIT(INT_INHIBIT), .RESET_PULSE(RESET_PULSE), .S_AXI_AWVALID(awv),
		.S_AXI_AWREADY(awr), .S_AXI_AWADDR(awa), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr),
		.S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_BVALID(bv), .S_AXI_BREADY(br),
		.S_AXI_BRESP(bresp), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara),
		.S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp));
	sfse_mem_model mem (.clk(CLK), .req(MEM_REQ), .rdata(MEM_RDATA));
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic give_up();
		fail_count++;
		report_and_stop();
	endtask
	// Outputs are looked at mid-cycle, where they are settled
	always @(negedge CLK)
	begin
		if (RESULT.valid === 1'b1)
			check("result", RESULT.data, rq.size() ? rq.pop_front() : 32'hX);
		if (MEM_REQ.we === 1'b1)
			check("stack write", {MEM_REQ.addr, MEM_REQ.wdata}, wq.size() ? wq.pop_front() : 32'hX);
		if (rv === 1'b1 && rr === 1'b1)
			check("register", rdata, aq.size() ? aq.pop_front() : 32'hX);
	end
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int i;
		logic aw_t;
		logic w_t;
		logic b_t;
		logic [1:0] resp;
		awv <= 1'b1;
		awa <= a;
		wv <= 1'b1;
		wd <= d;
		br <= 1'b1;
		resp = 2'h0;
		for (i = 0; i < 100; i++)
		begin
			@(negedge CLK);
			aw_t = awv && awr;
			w_t = wv && wr;
			b_t = bv;
			resp = bresp;
			@(posedge CLK);
			if (aw_t)
				awv <= 1'b0;
			if (w_t)
				wv <= 1'b0;
			if (b_t)
				break;
		end
		if (i == 100)
			give_up();
		check("write response", 32'(resp), 32'(er));
	endtask
	task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		int i;
		logic ar_t;
		logic r_t;
		logic [1:0] resp;
		arv <= 1'b1;
		ara <= a;
		rr <= 1'b1;
		aq.push_back(exp);
		resp = 2'h0;
		for (i = 0; i < 100; i++)
		begin
			@(negedge CLK);
			ar_t = arv && arr;
			r_t = rv;
			resp = rresp;
			@(posedge CLK);
			if (ar_t)
				arv <= 1'b0;
			if (r_t)
				break;
		end
		if (i == 100)
			give_up();
		check("read response", 32'(resp), 32'(er));
	endtask
	// Waits for the take, then for readiness to return so results have landed
	task automatic run(input logic [7:0] o, input logic [7:0] x, input logic [31:0] v,
		input logic [7:0] c);
		int i;
		INSTR_VALID <= 1'b1;
		INSTR <= '{opcode: o, aux: x, count_reg: c, operand: v, next_pc: npc};
		for (i = 0; i < 100; i++)
		begin
			@(negedge CLK);
			if (INSTR_READY)
				break;
		end
		if (i == 100)
			give_up();
		@(posedge CLK);
		INSTR_VALID <= 1'b0;
		for (i = 0; i < 100; i++)
		begin
			@(negedge CLK);
			if (INSTR_READY)
				break;
		end
		if (i == 100)
			give_up();
		@(posedge CLK);
	endtask
	function automatic logic [47:0] shl_ref(input logic [31:0] v, input logic [4:0] n,
		input int w, input logic [15:0] f);
		logic c;
		logic ov;
		c = f[11];
		ov = 1'b0;
		repeat (n)
		begin
			c = v[w-1];
			v = (w == 32) ? v << 1 : (v << 1) & ((32'h1 << w) - 32'h1);
			ov = ov | (v[w-1] != c);
		end
		f[15] = (v == 32'h0);
		f[13] = ov;
		f[12] = f[12] | ov;
		f[11] = c;
		return {f, v};
	endfunction
	initial
	begin
		int k;
		int w;
		logic [7:0] o, x, c;
		logic [31:0] v;
		logic [47:0] r;
		logic [10:0] d;
		void'($urandom(32'hFEEA));
		repeat (12) @(posedge CLK);
		RST_N <= 1'b1;
		@(posedge CLK);
		axi_rd(`SFSE_REG_STACK, 32'h0, `SFSE_RESP_OKAY);
		axi_rd(`SFSE_REG_PC, 32'h2080, `SFSE_RESP_OKAY);
		axi_wr(`SFSE_REG_PC, 32'h0, `SFSE_RESP_OKAY);
		axi_rd(`SFSE_REG_PC, 32'h2080, `SFSE_RESP_OKAY);
		axi_wr(8'h40, $urandom, `SFSE_RESP_SLVERR);
		axi_rd(8'h40, 32'h0, `SFSE_RESP_SLVERR);
		$display("test registers done");
		stk = 16'h1000 + (16'($urandom) & 16'h3FFE);
		axi_wr(`SFSE_REG_STACK, {16'h0, stk}, `SFSE_RESP_OKAY);
		for (k = 0; k < 4; k++)
		begin
			v = $urandom;
			npc = 16'($urandom);
			wq.push_back({stk - 16'h2, v[15:0]});
			run({6'h32, 2'(k)}, 8'h00, v, 8'h00);
			rq.push_back({16'h0, v[15:0]});
			run({6'h33, 2'(k)}, 8'h00, 32'h0, 8'h00);
		end
		axi_rd(`SFSE_REG_STACK, {16'h0, stk}, `SFSE_RESP_OKAY);
		$display("test word push and pop done");
		fl = 16'($urandom) & 16'hFBFF;
		axi_wr(`SFSE_REG_FLAGS, {16'h0, fl}, `SFSE_RESP_OKAY);
		wq.push_back({stk - 16'h2, fl});
		run(8'hF2, 8'h00, 32'h0, 8'h00);
		axi_rd(`SFSE_REG_FLAGS, 32'h0, `SFSE_RESP_OKAY);
		axi_rd(`SFSE_REG_STATUS, 32'h2, `SFSE_RESP_OKAY);
		run(8'hF3, 8'h00, 32'h0, 8'h00);
		axi_rd(`SFSE_REG_FLAGS, {16'h0, fl}, `SFSE_RESP_OKAY);
		axi_rd(`SFSE_REG_STACK, {16'h0, stk}, `SFSE_RESP_OKAY);
		mk = 16'($urandom);
		axi_wr(`SFSE_REG_MASKS, {16'h0, mk}, `SFSE_RESP_OKAY);
		wq.push_back({stk - 16'h2, fl});
		wq.push_back({stk - 16'h4, mk});
		run(8'hF4, 8'h00, 32'h0, 8'h00);
		axi_rd(`SFSE_REG_FLAGS, 32'h0, `SFSE_RESP_OKAY);
		axi_rd(`SFSE_REG_MASKS, {24'h0, mk[7:0]}, `SFSE_RESP_OKAY);
		axi_rd(`SFSE_REG_STACK, {16'h0, stk - 16'h4}, `SFSE_RESP_OKAY);
		run(8'hF5, 8'h00, 32'h0, 8'h00);
		axi_rd(`SFSE_REG_FLAGS, {16'h0, fl}, `SFSE_RESP_OKAY);
		axi_rd(`SFSE_REG_MASKS, {16'h0, mk}, `SFSE_RESP_OKAY);
		axi_rd(`SFSE_REG_STACK, {16'h0, stk}, `SFSE_RESP_OKAY);
		$display("test flag and mask stack done");
		for (k = 0; k < 3; k++)
		begin
			d = (k == 0) ? 11'h400 : (k == 1) ? 11'h3FF : 11'($urandom);
			npc = 16'h4000 + 16'($urandom & 32'h3FFF);
			wq.push_back({stk - 16'h2, npc});
			run({5'h05, d[10:8]}, d[7:0], 32'h0, 8'h00);
			axi_rd(`SFSE_REG_PC, {16'h0, npc + {{5{d[10]}}, d}}, `SFSE_RESP_OKAY);
			v = {16'h0, npc};
			npc = 16'($urandom);
			run(8'hF0, 8'h00, 32'h0, 8'h00);
			axi_rd(`SFSE_REG_PC, v, `SFSE_RESP_OKAY);
			axi_rd(`SFSE_REG_STACK, {16'h0, stk}, `SFSE_RESP_OKAY);
		end
		fl = 16'($urandom) & 16'hF3FF;
		axi_wr(`SFSE_REG_FLAGS, {16'h0, fl}, `SFSE_RESP_OKAY);
		run(8'hF9, 8'h00, 32'h0, 8'h00);
		axi_rd(`SFSE_REG_FLAGS, {16'h0, fl | 16'h0800}, `SFSE_RESP_OKAY);
		$display("test call return carry done");
		for (k = 0; k < 9; k++)
		begin
			o = (k % 3 == 0) ? 8'h09 : (k % 3 == 1) ? 8'h19 : 8'h0D;
			w = (k % 3 == 0) ? 16 : (k % 3 == 1) ? 8 : 32;
			x = (k < 3) ? 8'h00 : (k < 6) ? 8'h0F : 8'h10 + 8'($urandom % 240);
			c = 8'($urandom);
			fl = 16'($urandom) & 16'hFBFF;
			v = $urandom;
			v = (w == 32) ? v : v & ((32'h1 << w) - 32'h1);
			r = shl_ref(v, (x < 8'h10) ? x[4:0] : c[4:0], w, fl);
			axi_wr(`SFSE_REG_FLAGS, {16'h0, fl}, `SFSE_RESP_OKAY);
			rq.push_back(r[31:0]);
			run(o, x, v, c);
			axi_rd(`SFSE_REG_FLAGS, {16'h0, r[47:32]}, `SFSE_RESP_OKAY);
		end
		$display("test left shifts done");
		run(8'hFF, 8'h00, 32'h0, 8'h00);
		axi_rd(`SFSE_REG_PC, 32'h2080, `SFSE_RESP_OKAY);
		axi_rd(`SFSE_REG_FLAGS, 32'h0, `SFSE_RESP_OKAY);
		axi_rd(`SFSE_REG_MASKS, 32'h0, `SFSE_RESP_OKAY);
		repeat (8) @(posedge CLK);
		$display("test software reset done");
		report_and_stop();
	end
endmodule // test_stack_flag_shift_exec
